/* hw/acmpc_chan.sv */
`timescale 1ns/1ps
module acmpc_chan #(
  parameter bit HAS_LCD_REF = 1'b0
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  // Configuration
  input  wire logic                    enable,
  input  wire logic                    invert_select,
  input  wire logic                    hysteresis_enable,
  input  wire logic                    sync_mode,
  input  wire logic                    rise_irq_enable,
  input  wire logic                    fall_irq_enable,
  input  wire acmpc_pkg::acmpc_sel_t   neg_channel_select,
  input  wire acmpc_pkg::acmpc_sel_t   pos_channel_select,
  // Analog core and timer clock
  input  wire logic                    core_raw,
  input  wire logic                    t1_clk_src,
  // Results and analog core controls
  output logic                         result_q,
  output logic                         edge_evt_q,
  output logic                         ext_out_q,
  output logic                         core_en_q,
  output logic                         core_hyst_q,
  output acmpc_pkg::acmpc_nroute_t     neg_route_q,
  output acmpc_pkg::acmpc_proute_t     pos_route_q
);
  import acmpc_pkg::*;

  logic          result_d;
  logic          prev_q;
  logic          t1_prev_q;
  logic          t1_fall;
  logic          rise_hit;
  logic          fall_hit;
  acmpc_nroute_t neg_route_d;
  acmpc_proute_t pos_route_d;

  assign result_d = (enable & core_raw) ^ invert_select;
  assign t1_fall  = t1_prev_q & ~t1_clk_src;
  assign rise_hit = rise_irq_enable & result_q & ~prev_q;
  assign fall_hit = fall_irq_enable & ~result_q & prev_q;

  always_comb begin
    neg_route_d = '0;
    pos_route_d = '0;
    if (enable) begin
      if (neg_channel_select <= ACMPC_NEG_PIN_MAX) begin
        neg_route_d[neg_channel_select] = 1'b1;
      end
      neg_route_d[ACMPC_NR_FIXREF] = (neg_channel_select == ACMPC_NEG_FIXREF);
      neg_route_d[ACMPC_NR_AVSS]   = (neg_channel_select == ACMPC_NEG_AVSS);
      pos_route_d[ACMPC_PR_PIN0]   = (pos_channel_select == ACMPC_POS_PIN0);
      pos_route_d[ACMPC_PR_PIN1]   = (pos_channel_select == ACMPC_POS_PIN1);
      pos_route_d[ACMPC_PR_LCDREF] = HAS_LCD_REF &&
        (pos_channel_select == ACMPC_POS_LCDREF);
      pos_route_d[ACMPC_PR_DAC]    = (pos_channel_select == ACMPC_POS_DAC);
      pos_route_d[ACMPC_PR_FIXREF] = (pos_channel_select == ACMPC_POS_FIXREF);
      pos_route_d[ACMPC_PR_AVSS]   = (pos_channel_select == ACMPC_POS_AVSS);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      result_q    <= 1'b0;
      prev_q      <= 1'b0;
      t1_prev_q   <= 1'b0;
      edge_evt_q  <= 1'b0;
      ext_out_q   <= 1'b0;
      core_en_q   <= 1'b0;
      core_hyst_q <= 1'b0;
      neg_route_q <= '0;
      pos_route_q <= '0;
    end else if (ce) begin
      result_q    <= result_d;
      prev_q      <= result_q;
      t1_prev_q   <= t1_clk_src;
      edge_evt_q  <= rise_hit | fall_hit;
      if (!sync_mode || t1_fall) begin
        ext_out_q <= result_d;
      end
      core_en_q   <= enable;
      core_hyst_q <= hysteresis_enable;
      neg_route_q <= neg_route_d;
      pos_route_q <= pos_route_d;
    end
  end

  property p_sync_hold;
    @(posedge ref_clk) disable iff (srst)
      (ce && sync_mode && !t1_fall) |=> $stable(ext_out_q);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("Synced output moved without a timer falling edge");

  property p_lcd_only_second;
    @(posedge ref_clk) disable iff (srst)
      !HAS_LCD_REF |-> !pos_route_q[ACMPC_PR_LCDREF];
  endproperty
  a_lcd_only_second: assert property (p_lcd_only_second)
    else $error("Display reference routed on first comparator");

endmodule : acmpc_chan

/* hw/acmpc_pkg.sv */
package acmpc_pkg;

  // Bus geometry
  localparam int ACMPC_AW        = 4;
  localparam int ACMPC_DW        = 8;
  localparam int ACMPC_NCMP      = 2;
  localparam int ACMPC_CH_STRIDE = 4;
  typedef logic [ACMPC_AW-1:0] acmpc_addr_t;
  typedef logic [ACMPC_DW-1:0] acmpc_data_t;
  typedef logic [2:0]          acmpc_sel_t;

  // Register indices, per comparator (add channel times stride)
  localparam acmpc_addr_t ACMPC_IDX_MAIN_CTRL = 4'h0;
  localparam acmpc_addr_t ACMPC_IDX_EDGE_CTRL = 4'h1;
  localparam acmpc_addr_t ACMPC_IDX_NEG_SEL   = 4'h2;
  localparam acmpc_addr_t ACMPC_IDX_POS_SEL   = 4'h3;
  // Shared registers
  localparam acmpc_addr_t ACMPC_IDX_MIRROR    = 4'h8;
  localparam acmpc_addr_t ACMPC_IDX_FLAGS     = 4'h9;

  localparam acmpc_data_t ACMPC_RESET = 8'h00;

  // Main control fields
  localparam int ACMPC_B_ENABLE = 7;
  localparam int ACMPC_B_RESULT = 6;
  localparam int ACMPC_B_INVERT = 4;
  localparam int ACMPC_B_HYST   = 1;
  localparam int ACMPC_B_SYNC   = 0;
  // Edge control fields
  localparam int ACMPC_B_RISE   = 1;
  localparam int ACMPC_B_FALL   = 0;
  // Select field
  localparam int ACMPC_SEL_LSB  = 0;
  localparam int ACMPC_SEL_MSB  = 2;
  // Mirror fields
  localparam int ACMPC_B_MIR_FIRST  = 0;
  localparam int ACMPC_B_MIR_SECOND = 1;

  // Negative select codes
  localparam acmpc_sel_t ACMPC_NEG_PIN_MAX = 3'h4;
  localparam acmpc_sel_t ACMPC_NEG_OPEN    = 3'h5;
  localparam acmpc_sel_t ACMPC_NEG_FIXREF  = 3'h6;
  localparam acmpc_sel_t ACMPC_NEG_AVSS    = 3'h7;
  // Positive select codes
  localparam acmpc_sel_t ACMPC_POS_PIN0    = 3'h0;
  localparam acmpc_sel_t ACMPC_POS_PIN1    = 3'h1;
  localparam acmpc_sel_t ACMPC_POS_LCDREF  = 3'h4;
  localparam acmpc_sel_t ACMPC_POS_DAC     = 3'h5;
  localparam acmpc_sel_t ACMPC_POS_FIXREF  = 3'h6;
  localparam acmpc_sel_t ACMPC_POS_AVSS    = 3'h7;

  // Analog switch vectors: one bit per source
  localparam int ACMPC_NEG_W       = 7;
  localparam int ACMPC_NR_FIXREF   = 5;
  localparam int ACMPC_NR_AVSS     = 6;
  localparam int ACMPC_POS_W       = 6;
  localparam int ACMPC_PR_PIN0     = 0;
  localparam int ACMPC_PR_PIN1     = 1;
  localparam int ACMPC_PR_LCDREF   = 2;
  localparam int ACMPC_PR_DAC      = 3;
  localparam int ACMPC_PR_FIXREF   = 4;
  localparam int ACMPC_PR_AVSS     = 5;
  typedef logic [ACMPC_NEG_W-1:0] acmpc_nroute_t;
  typedef logic [ACMPC_POS_W-1:0] acmpc_proute_t;

endpackage : acmpc_pkg

/* hw/acmpc_top.sv */
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Main control bit 7 enables the comparator; clear powers it down.
// - Main control bit 6 reads the polarity-adjusted comparator result.
// - Main control bit 4 inverts output for status, edges and consumers.
// - Main control bit 1 drives the analog hysteresis enable.
// - Main control bit 0 latches external output on timer clock falls.
// - Edge control bit 1 sets the flag on rising result edges.
// - Edge control bit 0 sets the flag on falling result edges.
// - Negative select: pins 0-4, open, fixed reference, analog ground.
// - Positive select: pins 0-1, open, display ref, DAC, reference, ground.
// - Display reference exists on the second comparator only.
// - Mirror register: bit 1 second result, bit 0 first result.
// - Unimplemented bits ignore writes and read as zero.
// - Edges set the flag; software clears; a coincident edge wins.
// - Toggling invert makes an edge, even when disabled; toggling enable does so only while the core output is high.
// - Result is registered every cycle; pin path only latched in sync mode.
// - With enable clear, all input channels are disconnected.
module acmpc_top (
  // Clock, reset, enable
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic                     ce,
  // Register port
  input  wire acmpc_pkg::acmpc_addr_t   addr,
  input  wire acmpc_pkg::acmpc_data_t   wdata,
  input  wire logic                     wr_stb,
  input  wire logic                     rd_stb,
  output acmpc_pkg::acmpc_data_t        rdata_q,
  // Analog core results and timer clock
  input  wire logic [1:0]               core_raw,
  input  wire logic                     t1_clk_src,
  // Analog core controls
  output logic [1:0]                    core_en_q,
  output logic [1:0]                    core_hyst_q,
  output acmpc_pkg::acmpc_nroute_t      inverting_node_route0_q,
  output acmpc_pkg::acmpc_nroute_t      inverting_node_route1_q,
  output acmpc_pkg::acmpc_proute_t      noninverting_node_route0_q,
  output acmpc_pkg::acmpc_proute_t      noninverting_node_route1_q,
  // Results to timer, pins and interrupt controller
  output logic [1:0]                    ext_out_q,
  output logic [1:0]                    comparator_irq_flag_q
);
  import acmpc_pkg::*;

  localparam int NCMP = ACMPC_NCMP;

  // Configuration registers
  logic       [NCMP-1:0] enable_q;
  logic       [NCMP-1:0] invert_select_q;
  logic       [NCMP-1:0] hyst_q;
  logic       [NCMP-1:0] sync_q;
  logic       [NCMP-1:0] rise_en_q;
  logic       [NCMP-1:0] fall_en_q;
  acmpc_sel_t            nsel_q [NCMP];
  acmpc_sel_t            psel_q [NCMP];

  // Channel outputs
  logic       [NCMP-1:0] result;
  logic       [NCMP-1:0] edge_evt;
  acmpc_nroute_t         nroute [NCMP];
  acmpc_proute_t         proute [NCMP];

  // Decode and read paths
  acmpc_data_t           rd_ch [NCMP];
  logic       [NCMP-1:0] flag_clr;
  logic       [NCMP-1:0] flag_d;
  wire                   sel_mirror = (addr == ACMPC_IDX_MIRROR);
  wire                   sel_flags  = (addr == ACMPC_IDX_FLAGS);
  acmpc_data_t           mirror_word;
  acmpc_data_t           flags_word;
  acmpc_data_t           rd_word;

  always_comb begin
    mirror_word = ACMPC_RESET;
    mirror_word[ACMPC_B_MIR_FIRST]  = result[0];
    mirror_word[ACMPC_B_MIR_SECOND] = result[1];
    flags_word  = ACMPC_RESET;
    flags_word[NCMP-1:0] = comparator_irq_flag_q;
  end

  assign rd_word = rd_ch[0] | rd_ch[1]
                 | (sel_mirror ? mirror_word : ACMPC_RESET)
                 | (sel_flags  ? flags_word  : ACMPC_RESET);

  for (genvar g = 0; g < NCMP; g++) begin : g_cmp
    localparam acmpc_addr_t BASE = acmpc_addr_t'(g * ACMPC_CH_STRIDE);
    wire         sel_main = (addr == BASE + ACMPC_IDX_MAIN_CTRL);
    wire         sel_edge = (addr == BASE + ACMPC_IDX_EDGE_CTRL);
    wire         sel_nsel = (addr == BASE + ACMPC_IDX_NEG_SEL);
    wire         sel_psel = (addr == BASE + ACMPC_IDX_POS_SEL);
    acmpc_data_t main_word;
    acmpc_data_t edge_word;
    acmpc_data_t nsel_word;
    acmpc_data_t psel_word;

    // Reserved positions stay zero on read
    always_comb begin
      main_word = ACMPC_RESET;
      main_word[ACMPC_B_ENABLE] = enable_q[g];
      main_word[ACMPC_B_RESULT] = result[g];
      main_word[ACMPC_B_INVERT] = invert_select_q[g];
      main_word[ACMPC_B_HYST]   = hyst_q[g];
      main_word[ACMPC_B_SYNC]   = sync_q[g];
      edge_word = ACMPC_RESET;
      edge_word[ACMPC_B_RISE]   = rise_en_q[g];
      edge_word[ACMPC_B_FALL]   = fall_en_q[g];
      nsel_word = ACMPC_RESET;
      nsel_word[ACMPC_SEL_MSB:ACMPC_SEL_LSB] = nsel_q[g];
      psel_word = ACMPC_RESET;
      psel_word[ACMPC_SEL_MSB:ACMPC_SEL_LSB] = psel_q[g];
    end

    assign rd_ch[g] = sel_main ? main_word :
                      sel_edge ? edge_word :
                      sel_nsel ? nsel_word :
                      sel_psel ? psel_word : ACMPC_RESET;

    assign flag_clr[g] = wr_stb && sel_flags && wdata[g];
    assign flag_d[g]   = (comparator_irq_flag_q[g] & ~flag_clr[g])
                       | edge_evt[g];

    // Only implemented bits are stored; writes to others are dropped
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        enable_q[g]        <= 1'b0;
        invert_select_q[g] <= 1'b0;
        hyst_q[g]          <= 1'b0;
        sync_q[g]          <= 1'b0;
        rise_en_q[g]       <= 1'b0;
        fall_en_q[g]       <= 1'b0;
        nsel_q[g]          <= '0;
        psel_q[g]          <= '0;
      end else if (ce && wr_stb) begin
        if (sel_main) begin
          enable_q[g]        <= wdata[ACMPC_B_ENABLE];
          invert_select_q[g] <= wdata[ACMPC_B_INVERT];
          hyst_q[g]          <= wdata[ACMPC_B_HYST];
          sync_q[g]          <= wdata[ACMPC_B_SYNC];
        end
        if (sel_edge) begin
          rise_en_q[g] <= wdata[ACMPC_B_RISE];
          fall_en_q[g] <= wdata[ACMPC_B_FALL];
        end
        if (sel_nsel) begin
          nsel_q[g] <= wdata[ACMPC_SEL_MSB:ACMPC_SEL_LSB];
        end
        if (sel_psel) begin
          psel_q[g] <= wdata[ACMPC_SEL_MSB:ACMPC_SEL_LSB];
        end
      end
    end

    acmpc_chan #(
      .HAS_LCD_REF (g == 1)
    ) u_chan (
      .ref_clk            (ref_clk),
      .srst               (srst),
      .ce                 (ce),
      .enable             (enable_q[g]),
      .invert_select      (invert_select_q[g]),
      .hysteresis_enable  (hyst_q[g]),
      .sync_mode          (sync_q[g]),
      .rise_irq_enable    (rise_en_q[g]),
      .fall_irq_enable    (fall_en_q[g]),
      .neg_channel_select (nsel_q[g]),
      .pos_channel_select (psel_q[g]),
      .core_raw           (core_raw[g]),
      .t1_clk_src         (t1_clk_src),
      .result_q           (result[g]),
      .edge_evt_q         (edge_evt[g]),
      .ext_out_q          (ext_out_q[g]),
      .core_en_q          (core_en_q[g]),
      .core_hyst_q        (core_hyst_q[g]),
      .neg_route_q        (nroute[g]),
      .pos_route_q        (proute[g])
    );

    property p_flag_set;
      @(posedge ref_clk) disable iff (srst)
        (ce && edge_evt[g]) |=> comparator_irq_flag_q[g];
    endproperty
    a_flag_set: assert property (p_flag_set)
      else $error("Edge event did not set the flag");

    property p_route_off;
      @(posedge ref_clk) disable iff (srst)
        (ce && !enable_q[g]) |=> (nroute[g] == '0) && (proute[g] == '0);
    endproperty
    a_route_off: assert property (p_route_off)
      else $error("Input routed while comparator disabled");

    property p_result;
      @(posedge ref_clk) disable iff (srst)
        ce |=> result[g] == ($past(enable_q[g] & core_raw[g])
                             ^ $past(invert_select_q[g]));
    endproperty
    a_result: assert property (p_result)
      else $error("Result not polarity-adjusted raw output");

    property p_rise;
      @(posedge ref_clk) disable iff (srst)
        ce ##1 (ce && rise_en_q[g] && $rose(result[g]))
          |=> edge_evt[g];
    endproperty
    a_rise: assert property (p_rise)
      else $error("Rising edge missed");

    property p_fall;
      @(posedge ref_clk) disable iff (srst)
        ce ##1 (ce && fall_en_q[g] && $fell(result[g]))
          |=> edge_evt[g];
    endproperty
    a_fall: assert property (p_fall)
      else $error("Falling edge missed");

    property p_enable_pin;
      @(posedge ref_clk) disable iff (srst)
        (ce && wr_stb && sel_main) ##1 ce
          |=> core_en_q[g] == $past(wdata[ACMPC_B_ENABLE], 2);
    endproperty
    a_enable_pin: assert property (p_enable_pin)
      else $error("Enable write not reflected on core enable");

    property p_hyst_pin;
      @(posedge ref_clk) disable iff (srst)
        (ce && wr_stb && sel_main) ##1 ce
          |=> core_hyst_q[g] == $past(wdata[ACMPC_B_HYST], 2);
    endproperty
    a_hyst_pin: assert property (p_hyst_pin)
      else $error("Hysteresis write not reflected");

    property p_pol_edge;
      @(posedge ref_clk) disable iff (srst)
        (ce && !enable_q[g] && rise_en_q[g] && fall_en_q[g]
         && $changed(invert_select_q[g])) ##1 ce
          |=> edge_evt[g];
    endproperty
    a_pol_edge: assert property (p_pol_edge)
      else $error("Invert toggle gave no edge while disabled");

    c_rise: cover property (@(posedge ref_clk) disable iff (srst)
      edge_evt[g] && result[g]);
    c_fall: cover property (@(posedge ref_clk) disable iff (srst)
      edge_evt[g] && !result[g]);
    c_set_clr: cover property (@(posedge ref_clk) disable iff (srst)
      edge_evt[g] && flag_clr[g]);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q               <= ACMPC_RESET;
      comparator_irq_flag_q <= '0;
    end else if (ce) begin
      rdata_q               <= rd_stb ? rd_word : ACMPC_RESET;
      comparator_irq_flag_q <= flag_d;
    end
  end

  assign inverting_node_route0_q    = nroute[0];
  assign inverting_node_route1_q    = nroute[1];
  assign noninverting_node_route0_q = proute[0];
  assign noninverting_node_route1_q = proute[1];

  property p_neg_ground;
    @(posedge ref_clk) disable iff (srst)
      (ce && enable_q[0] && nsel_q[0] == ACMPC_NEG_AVSS)
        |=> nroute[0] == acmpc_nroute_t'(1 << ACMPC_NR_AVSS);
  endproperty
  a_neg_ground: assert property (p_neg_ground)
    else $error("Ground not routed to inverting node");

  property p_pos_dac;
    @(posedge ref_clk) disable iff (srst)
      (ce && enable_q[1] && psel_q[1] == ACMPC_POS_DAC)
        |=> proute[1] == acmpc_proute_t'(1 << ACMPC_PR_DAC);
  endproperty
  a_pos_dac: assert property (p_pos_dac)
    else $error("DAC not routed to noninverting node");

  property p_mirror;
    @(posedge ref_clk) disable iff (srst)
      (ce && rd_stb && sel_mirror)
        |=> rdata_q == acmpc_data_t'($past(result));
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("Mirror read wrong");

  property p_reserved;
    @(posedge ref_clk) disable iff (srst)
      (ce && rd_stb && addr == ACMPC_IDX_EDGE_CTRL)
        |=> rdata_q[ACMPC_DW-1:ACMPC_B_RISE+1] == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bits read nonzero");

  property p_invert_out;
    @(posedge ref_clk) disable iff (srst)
      (ce && !sync_q[0]) |=> ext_out_q[0] == result[0];
  endproperty
  a_invert_out: assert property (p_invert_out)
    else $error("Pin output differs from adjusted result");

  c_mirror_read: cover property (@(posedge ref_clk) disable iff (srst)
    rd_stb && sel_mirror && result == 2'b11);

endmodule : acmpc_top

/* sim/acmpc_core_model.sv */
`timescale 1ns/1ps
module acmpc_core_model (
  // Clock
  input  wire logic       ref_clk,
  // Wanted decisions, timer run request and core enables
  input  wire logic [1:0] want,
  input  wire logic       t1_run,
  input  wire logic [1:0] core_en_q,
  // Decisions and timer clock
  output logic [1:0]      core_raw,
  output logic            t1_clk_src
);
  logic       tog_q;
  logic [2:0] div_q;

  initial begin
    tog_q = 1'b0;
    div_q = 3'h0;
  end

  // Timer clock runs only while asked, else stands still low
  always @(posedge ref_clk) begin
    tog_q <= ~tog_q;
    if (t1_run) begin
      div_q <= div_q + 3'h1;
    end else begin
      div_q <= 3'h0;
    end
  end

  // A powered-down core gives no decision: show a changing pattern
  assign core_raw[0] = core_en_q[0] ? want[0] : tog_q;
  assign core_raw[1] = core_en_q[1] ? want[1] : ~tog_q;
  assign t1_clk_src  = div_q[2];
endmodule : acmpc_core_model

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  import acmpc_pkg::*;
  logic          ref_clk, srst, ce, wr_stb, rd_stb, t1_run, t1_clk_src;
  acmpc_addr_t   addr;
  acmpc_data_t   wdata, rdata_q;
  logic [1:0]    want, core_raw, core_en_q, core_hyst_q, ext_out_q, flag_q;
  acmpc_nroute_t nr0, nr1;
  acmpc_proute_t pr0, pr1;
  int            num_errors, comparisons, cycles;

  acmpc_top i_dut (.ref_clk(ref_clk), .srst(srst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
    .core_raw(core_raw), .t1_clk_src(t1_clk_src), .core_en_q(core_en_q),
    .core_hyst_q(core_hyst_q), .inverting_node_route0_q(nr0),
    .inverting_node_route1_q(nr1), .noninverting_node_route0_q(pr0),
    .noninverting_node_route1_q(pr1), .ext_out_q(ext_out_q),
    .comparator_irq_flag_q(flag_q));
  acmpc_core_model i_core (.ref_clk(ref_clk), .want(want), .t1_run(t1_run),
    .core_en_q(core_en_q), .core_raw(core_raw), .t1_clk_src(t1_clk_src));

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  task automatic print_verdict;
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata_q, exp);
  endtask : rd_chk

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt

  function automatic logic [7:0] neg_exp(input logic [2:0] c);
    case (c)
      3'h5: return 8'h00;
      3'h6: return 8'h20;
      3'h7: return 8'h40;
      default: return 8'h01 << c;
    endcase
  endfunction : neg_exp

  function automatic logic [7:0] pos_exp(input logic [2:0] c, input bit sec);
    case (c)
      3'h0: return 8'h01;
      3'h1: return 8'h02;
      3'h4: return sec ? 8'h04 : 8'h00;
      3'h5: return 8'h08;
      3'h6: return 8'h10;
      3'h7: return 8'h20;
      default: return 8'h00;
    endcase
  endfunction : pos_exp

  task automatic t_reset;
    for (int i = 0; i < 16; i++) begin
      rd_chk(4'(i), 8'h00);
    end
  endtask : t_reset

  task automatic t_fields;
    for (int g = 0; g < 2; g++) begin
      for (int r = 0; r < 4; r++) begin
        wr(4'(4 * g + r), 8'hff);
      end
      wt(3);
      rd_chk(4'(4 * g), 8'hd3);
      rd_chk(4'(4 * g + 1), 8'h03);
      rd_chk(4'(4 * g + 2), 8'h07);
      rd_chk(4'(4 * g + 3), 8'h07);
      chk({6'h0, core_en_q}, g ? 8'h03 : 8'h01);
      chk({6'h0, core_hyst_q}, g ? 8'h03 : 8'h01);
    end
    wr(4'h8, 8'hff);
    rd_chk(4'h8, 8'h03);
    for (int r = 0; r < 8; r++) begin
      wr(4'(r), 8'h00);
    end
    wt(4);
    wr(4'h9, 8'h03);
    chk({6'h0, core_en_q}, 8'h00);
  endtask : t_fields

  task automatic t_routes;
    wr(4'h0, 8'h80);
    wr(4'h4, 8'h80);
    for (int c = 0; c < 8; c++) begin
      wr(4'h2, 8'(c));
      wr(4'h3, 8'(c));
      wr(4'h6, 8'(c));
      wr(4'h7, 8'(c));
      wt(2);
      chk({1'b0, nr0}, neg_exp(3'(c)));
      chk({2'b0, pr0}, pos_exp(3'(c), 1'b0));
      chk({1'b0, nr1}, neg_exp(3'(c)));
      chk({2'b0, pr1}, pos_exp(3'(c), 1'b1));
    end
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h00);
    wt(2);
    chk({1'b0, nr0 | nr1}, 8'h00);
    chk({2'b0, pr0 | pr1}, 8'h00);
  endtask : t_routes

  task automatic t_mirror;
    want <= 2'b10;
    wr(4'h0, 8'h80);
    wr(4'h4, 8'h80);
    wt(4);
    rd_chk(4'h8, 8'h02);
    rd_chk(4'h0, 8'h80);
    rd_chk(4'h4, 8'hc0);
    chk({6'h0, ext_out_q}, 8'h02);
    wr(4'h0, 8'h90);
    wt(3);
    rd_chk(4'h8, 8'h03);
    rd_chk(4'h0, 8'hd0);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h00);
    want <= 2'b00;
    wt(4);
    wr(4'h9, 8'h03);
  endtask : t_mirror

  task automatic t_edges;
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h02);
    wt(4);
    wr(4'h9, 8'h03);
    wt(1);
    chk({6'h0, flag_q}, 8'h00);
    want <= 2'b01;
    wt(4);
    chk({6'h0, flag_q}, 8'h01);
    rd_chk(4'h9, 8'h01);
    wr(4'h9, 8'h01);
    wt(1);
    chk({6'h0, flag_q}, 8'h00);
    want <= 2'b00;
    wt(4);
    chk({6'h0, flag_q}, 8'h00);
    // Clear strobe lands in the same cycle as a rising edge event
    want <= 2'b01;
    wt(1);
    wr(4'h9, 8'h01);
    wt(1);
    chk({6'h0, flag_q}, 8'h01);
    want <= 2'b00;
    wt(4);
    wr(4'h9, 8'h01);
    wt(1);
    chk({6'h0, flag_q}, 8'h00);
    wr(4'h1, 8'h01);
    want <= 2'b01;
    wt(4);
    chk({6'h0, flag_q}, 8'h00);
    want <= 2'b00;
    wt(4);
    chk({6'h0, flag_q}, 8'h01);
    wt(8);
    chk({6'h0, flag_q}, 8'h01);
    wr(4'h0, 8'h00);
    wr(4'h5, 8'h02);
    wr(4'h9, 8'h03);
    wr(4'h4, 8'h10);
    wt(4);
    chk({6'h0, flag_q}, 8'h02);
    want <= 2'b10;
    wr(4'h9, 8'h03);
    wr(4'h5, 8'h01);
    wr(4'h4, 8'h90);
    wt(4);
    chk({6'h0, flag_q}, 8'h02);
    for (int r = 0; r < 8; r++) begin
      wr(4'(r), 8'h00);
    end
    want <= 2'b00;
    wt(4);
    wr(4'h9, 8'h03);
  endtask : t_edges

  task automatic t_sync;
    wr(4'h0, 8'h81);
    wt(4);
    want <= 2'b01;
    wt(10);
    chk({7'h0, ext_out_q[0]}, 8'h00);
    rd_chk(4'h0, 8'hc1);
    t1_run <= 1'b1;
    wt(20);
    chk({7'h0, ext_out_q[0]}, 8'h01);
    t1_run <= 1'b0;
    wr(4'h0, 8'h80);
    want <= 2'b00;
    wt(3);
    chk({7'h0, ext_out_q[0]}, 8'h00);
    wr(4'h0, 8'h00);
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(4'h1, 8'h03);
    ce <= 1'b1;
    rd_chk(4'h1, 8'h00);
  endtask : t_sync

  initial begin
    srst   = 1'b1;
    ce     = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr   = 4'h0;
    wdata  = 8'h00;
    want   = 2'b00;
    t1_run = 1'b0;
    num_errors  = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_fields();
    t_routes();
    t_mirror();
    t_edges();
    t_sync();
    print_verdict();
  end
endmodule : tb
